// file: nvm_config_store_control.sv
// Non-volatile configuration store control with its shadow registers.
//
// Contract
// - Control bit 7 reads 0 while burning or reloading, 1 when idle.
// - Writing 1 to bit 1 after arming with bit 2 copies the shadow bytes into the store.
// - A burn lasts about 20 ms with the ready flag low throughout.
// - Shadow writes take effect at once, burned or not, unless a reload writes that byte in the same cycle.
// - Unburned shadow values are lost at reset; the store keeps burned ones.
// - After every reset the store is copied into the shadow bytes.
`timescale 1ns/100ps
`include "nvmcs_map.svh"
module nvm_config_store_control import nvmcs_pkg::*; #(
	parameter int BURN_CYCLES = `NVMCS_BURN_CYCLES,
	parameter int NBYTES = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic store_ready_flag,
	output logic [8*NBYTES-1:0] shadow_cfg
);
	////////////////////////////////////////////////////////////////////////
	// Refuse settings the sequencer cannot serve.
	generate
		if (BURN_CYCLES < NBYTES + 1 || NBYTES != 8) begin : g_chk
			$error("BURN_CYCLES must exceed NBYTES and NBYTES must be 8");
		end
	endgenerate

	nvmcs_state_t state_q, state_d;
	logic [2:0] ctl_q, ctl_d;
	logic [31:0] cnt_q, cnt_d;
	logic [3:0] idx_q, idx_d;
	logic ready_q, ready_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] shad_q [NBYTES];
	logic [7:0] shad_d [NBYTES];
	logic ctl_wr, burn_go, load_go, mem_wr;
	logic [2:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata;

	////////////////////////////////////////////////////////////////////////
	// Store array; burn writes a byte per cycle, reload reads one per cycle.
	nvmcs_nvm_array #(.DEPTH(NBYTES), .WIDTH(8), .AW(3)) u_nvm (
		.clk(clk),
		.wr_en(mem_wr),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	// Request decode: a request needs a prior arm and an idle store.
	always_comb begin
		ctl_wr = reg_wr && reg_addr == `NVMCS_CTRL_ADDR;
		burn_go = ctl_wr && reg_wdata[`NVMCS_BURN_BIT] && ctl_q[`NVMCS_ARM_BIT]
			&& state_q == NVMCS_IDLE;
		load_go = ctl_wr && reg_wdata[`NVMCS_RELOAD_BIT]
			&& !reg_wdata[`NVMCS_BURN_BIT] && ctl_q[`NVMCS_ARM_BIT]
			&& state_q == NVMCS_IDLE;
		mem_wr = state_q == NVMCS_BURN && idx_q < 4'(NBYTES);
		mem_addr = idx_q[2:0];
		mem_wdata = shad_q[idx_q[2:0]];
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer: reset lands in a reload, so the shadow bytes are always restored from the store.
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		idx_d = idx_q;
		ctl_d = ctl_q;
		if (ctl_wr) begin
			ctl_d = reg_wdata[2:0]; // Bits 6 to 3 are not stored.
		end
		case (state_q)
			NVMCS_IDLE: begin
				cnt_d = '0;
				idx_d = '0;
				if (burn_go) begin
					state_d = NVMCS_BURN;
				end else if (load_go) begin
					state_d = NVMCS_LOAD;
				end
			end
			NVMCS_BURN: begin
				cnt_d = cnt_q + 32'h0000_0001;
				if (idx_q < 4'(NBYTES)) begin
					idx_d = idx_q + 4'h1;
				end
				if (cnt_q == 32'(BURN_CYCLES - 1)) begin
					state_d = NVMCS_IDLE; // Burn time elapsed.
				end
			end
			NVMCS_LOAD: begin
				idx_d = idx_q + 4'h1;
				if (idx_q == 4'(NBYTES)) begin
					state_d = NVMCS_IDLE;
				end
			end
			default: begin
				state_d = NVMCS_IDLE;
			end
		endcase
		ready_d = state_d == NVMCS_IDLE;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= NVMCS_LOAD;
			cnt_q <= '0;
			idx_q <= '0;
			ctl_q <= 3'(`NVMCS_CTRL_RESET);
			ready_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			ctl_q <= ctl_d;
			ready_q <= ready_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shadow bytes: host writes act at once, reload data wins a collision.
	generate
		for (genvar k = 0; k < NBYTES; k++) begin : g_shad
			always_comb begin
				shad_d[k] = shad_q[k];
				if (reg_wr && reg_addr == `NVMCS_SHADOW_BASE + 8'(k)) begin
					shad_d[k] = reg_wdata;
				end
				if (state_q == NVMCS_LOAD && idx_q == 4'(k + 1)) begin
					shad_d[k] = mem_rdata;
				end
			end
			always_ff @(posedge clk) begin
				if (!rstn) begin
					shad_q[k] <= `NVMCS_SHADOW_RESET; // Volatile.
				end else begin
					shad_q[k] <= shad_d[k];
				end
			end
			assign shadow_cfg[8*k +: 8] = shad_q[k];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read data follow the address every cycle, one cycle late.
	always_comb begin
		if (reg_addr == `NVMCS_CTRL_ADDR) begin
			rdata_d = {ready_q, 4'h0, ctl_q};
		end else if (reg_addr >= `NVMCS_SHADOW_BASE
				&& reg_addr <= `NVMCS_SHADOW_LAST) begin
			rdata_d = shad_q[reg_addr[2:0]];
		end else begin
			rdata_d = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign store_ready_flag = ready_q;

	////////////////////////////////////////////////////////////////////////
	// Checks on the sequencer and the register view.
	property p_ready_idle;
		@(posedge clk) disable iff (!rstn)
		store_ready_flag == (state_q == NVMCS_IDLE);
	endproperty
	a_ready_idle: assert property (p_ready_idle)
		else $error("ready flag disagrees with store state");

	property p_burn_copy;
		@(posedge clk) disable iff (!rstn)
		burn_go |=> mem_wr && mem_addr == 3'h0 && mem_wdata == shad_q[0];
	endproperty
	a_burn_copy: assert property (p_burn_copy)
		else $error("accepted burn did not write first byte");

	property p_burn_busy;
		@(posedge clk) disable iff (!rstn)
		burn_go |=> !store_ready_flag [*8];
	endproperty
	a_burn_busy: assert property (p_burn_busy)
		else $error("ready rose too early during burn");

	// Ready comes back on the edge that ends the count, never earlier.
	property p_burn_end;
		@(posedge clk) disable iff (!rstn)
		state_q == NVMCS_BURN
			|=> store_ready_flag == ($past(cnt_q) == 32'(BURN_CYCLES - 1));
	endproperty
	a_burn_end: assert property (p_burn_end)
		else $error("burn did not end at its count");

	property p_shadow_now;
		@(posedge clk) disable iff (!rstn)
		reg_wr && reg_addr == `NVMCS_SHADOW_BASE && state_q != NVMCS_LOAD
			|=> shad_q[0] == $past(reg_wdata);
	endproperty
	a_shadow_now: assert property (p_shadow_now)
		else $error("shadow write did not take effect");

	property p_volatile;
		@(posedge clk) !rstn |=> shad_q[0] == `NVMCS_SHADOW_RESET;
	endproperty
	a_volatile: assert property (p_volatile)
		else $error("shadow byte survived reset");

	property p_boot_load;
		@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> !store_ready_flag ##[8:12] store_ready_flag;
	endproperty
	a_boot_load: assert property (p_boot_load)
		else $error("startup reload did not finish in time");

	// A running operation may end on its own, so only an idle store is held.
	property p_need_arm;
		@(posedge clk) disable iff (!rstn)
		ctl_wr && !ctl_q[`NVMCS_ARM_BIT] && state_q == NVMCS_IDLE
			|=> state_q == NVMCS_IDLE;
	endproperty
	a_need_arm: assert property (p_need_arm)
		else $error("operation started without arming");

	property p_rsvd_zero;
		@(posedge clk) disable iff (!rstn)
		$past(reg_addr) == `NVMCS_CTRL_ADDR |-> reg_rdata[6:3] == 4'h0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved control bits read nonzero");

	property p_busy_refuse;
		@(posedge clk) disable iff (!rstn)
		!store_ready_flag && ctl_wr |-> !burn_go && !load_go;
	endproperty
	a_busy_refuse: assert property (p_busy_refuse)
		else $error("request accepted while busy");

	c_burn: cover property (@(posedge clk) disable iff (!rstn) burn_go);
	c_load: cover property (@(posedge clk) disable iff (!rstn) load_go);
	c_refused: cover property (@(posedge clk) disable iff (!rstn)
		ctl_wr && reg_wdata[1] && !ctl_q[2]);
endmodule // nvm_config_store_control

// file: nvm_config_store_control_bench.sv
// Self-checking bench for the store control block.
`timescale 1ns/100ps
module nvm_config_store_control_bench;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} nvmcs_row_t;
	localparam int BURN = 32;
	localparam logic [63:0] CFG1 = 64'h0123456789abcdef;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic reg_wr;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
	logic store_ready_flag;
	logic [63:0] shadow_cfg;
	int n_errors = 0;
	int checks = 0;
	int lo = 0;
	nvmcs_row_t rows [6] = '{'{8'ha0, 8'h3c, 8'h3c}, '{8'ha7, 8'hc5, 8'hc5},
		'{8'h72, 8'h7c, 8'h84}, '{8'h72, 8'h00, 8'h80},
		'{8'h55, 8'h11, 8'h80}, '{8'ha3, 8'hff, 8'hff}};
	nvm_config_store_control #(.BURN_CYCLES(BURN), .NBYTES(8)) dut (
		.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.store_ready_flag(store_ready_flag), .shadow_cfg(shadow_cfg));
	nvmcs_host host (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	////////////////////////////////////////////////////////////////////////
	// Clock of 4 ns and a count of busy cycles seen at falling edges.
	initial forever #2 clk = ~clk;
	always @(negedge clk) lo += int'(store_ready_flag === 1'b0);
	// Compare and report one value.
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Wait for the ready flag under a bound.
	task automatic wait_ready();
		int n;
		n = 0;
		repeat (2) @(negedge clk);
		while (store_ready_flag !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// Print the counts and the verdict, then stop.
	task automatic test_done();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Cut a hang short well past the expected run length.
	initial begin
		repeat (20000) @(negedge clk);
		n_errors++;
		test_done();
	end
	// Main sequence: reset, table rows, then the awkward cases.
	initial begin
		repeat (16) @(negedge clk);
		chk(64'(store_ready_flag), 64'h0);
		rstn = 1'b1;
		wait_ready();
		chk(shadow_cfg, 64'h0);
		foreach (rows[i]) begin
			host.wr(rows[i].a, rows[i].d);
			@(negedge clk);
			if (rows[i].a[7:4] == 4'ha) begin
				chk(64'(shadow_cfg[8*rows[i].a[2:0] +: 8]), 64'(rows[i].e));
			end else begin
				host.rd(8'h72, rd_v);
				chk(64'(rd_v), 64'(rows[i].e));
			end
		end
		@(posedge clk);
		lo = 0;
		host.wr(8'h72, 8'h06);
		repeat (3) @(negedge clk);
		chk(64'(lo), 64'h0);
		host.wr(8'h72, 8'h00);
		@(posedge clk);
		lo = 0;
		host.start(CFG1, 8'h02);
		host.rd(8'h72, rd_v);
		chk(64'(rd_v), 64'h02);
		host.wr(8'h72, 8'h04);
		host.wr(8'h72, 8'h01);
		wait_ready();
		chk(64'(lo >= BURN - 1 && lo <= BURN), 64'h1);
		@(posedge clk);
		lo = 0;
		repeat (4) @(negedge clk);
		chk(64'(lo), 64'h0);
		host.wr(8'h72, 8'h00);
		host.wr(8'ha0, 8'h99);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		wait_ready();
		chk(shadow_cfg, CFG1);
		@(posedge clk);
		lo = 0;
		host.start(~CFG1, 8'h01);
		wait_ready();
		chk(shadow_cfg, CFG1);
		chk(64'(lo >= 8 && lo <= 9), 64'h1);
		@(posedge clk);
		lo = 0;
		host.wr(8'h72, 8'h04);
		host.wr(8'h72, 8'h03);
		wait_ready();
		chk(64'(lo >= BURN - 1 && lo <= BURN), 64'h1);
		host.wr(8'h72, 8'h00);
		test_done();
	end
endmodule // nvm_config_store_control_bench

// file: nvmcs_host.sv
// Host model that drives the store control register port.
`timescale 1ns/100ps
module nvmcs_host (
	input wire logic clk,
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// The bus idles with the strobe low from time zero.
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// One write strobe, raised and dropped on falling edges.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// Present an address and take the registered answer a cycle later.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask
	// Write 05 to the unmapped address 01, fill the shadow bytes, arm, then request the operation.
	task automatic start(input logic [63:0] cfg, input logic [7:0] req);
		wr(8'h01, 8'h05);
		for (int k = 0; k < 8; k++) begin
			wr(8'ha0 + 8'(k), cfg[8*k +: 8]);
		end
		wr(8'h72, 8'h04);
		wr(8'h72, req);
	endtask
endmodule // nvmcs_host

// file: nvmcs_map.svh
// Offsets, field positions, reset values and timing figures of the store control.
`ifndef NVMCS_MAP_SVH
`define NVMCS_MAP_SVH
`define NVMCS_CTRL_ADDR 8'h72
`define NVMCS_SHADOW_BASE 8'ha0
`define NVMCS_SHADOW_LAST 8'ha7
`define NVMCS_CTRL_RESET 8'h00
`define NVMCS_READY_BIT 7
`define NVMCS_ARM_BIT 2
`define NVMCS_BURN_BIT 1
`define NVMCS_RELOAD_BIT 0
`define NVMCS_SHADOW_RESET 8'h00
`define NVMCS_CLK_MHZ 250
`define NVMCS_BURN_TIME_MS 20
`define NVMCS_BURN_CYCLES (`NVMCS_BURN_TIME_MS * 1000 * `NVMCS_CLK_MHZ)
`endif

// file: nvmcs_nvm_array.sv
// Non-volatile byte array with one write port and a registered read port.
`timescale 1ns/100ps
module nvmcs_nvm_array #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 8,
	parameter int AW = 3
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Refuse a depth that the address cannot reach.
	generate
		if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
			$error("DEPTH must fit the address width");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// The cells have no reset: they keep their contents across device reset.
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = '0;
		end
	end

	// Writes store a byte; reads always come out one cycle later.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule // nvmcs_nvm_array

// file: nvmcs_pkg.sv
// Types shared by the store control files.
package nvmcs_pkg;
	typedef enum logic [2:0] {
		NVMCS_IDLE = 3'b001,
		NVMCS_BURN = 3'b010,
		NVMCS_LOAD = 3'b100
	} nvmcs_state_t;
endpackage
